// ==== hw/fcc_pkg.sv ====
// Package for the floppy control-command handler: constants, states, carriers
// Notes on behaviour
// - Seek or recalibrate end raises interrupt
// - Unsensed seek interrupt makes next command invalid
// - Head unload interval in 16 ms steps; the code times it in 0.8 ms steps
// - Unload interval runs from read/write end
// - Step spacing inversely coded 1 to 16 ms; the code spaces steps 0.1 to 1.6 ms
// - Head settle interval in 2 ms steps; the code stores it but never times it
// - Intervals scale with main clock rate; the code fixes them in real time from CLK_HZ and never uses REF_HZ
// - Transfer mode bit one selects non-DMA
// - Drive status query returns status register 3
// - Undefined command sets result bit7, clears bit6
// - No interrupt on undefined command
// - Invalid sets direction and request flags
// - Result read after invalid gives 80 hex
// - Standby and reset are single byte codes
// - Software reset equals hardware reset
// - Recalibrate steps up to 255 tracks
// - Index ignored 0.2 ms after a pulse
// - Multitrack write allowed with tunnel erase
// - Write timing clock high two periods
// - Step pulse high 6 to 8 us
// - Fault reset pulse high 8 to 10 us
// - Sense result codes seek end and cause
package fcc_pkg;
  // Register byte addresses on the bus
  localparam logic [3:0] ADDR_CMD = 4'h0;
  localparam logic [3:0] ADDR_MAIN = 4'h4;
  localparam logic [3:0] ADDR_RESULT = 4'h8;
  localparam logic [3:0] ADDR_DRIVE = 4'hc;
  // Command codes
  localparam logic [7:0] CMD_SPECIFY = 8'h03;
  localparam logic [7:0] CMD_DRIVE_STATUS = 8'h04;
  localparam logic [7:0] CMD_RECAL = 8'h07;
  localparam logic [7:0] CMD_SENSE = 8'h08;
  localparam logic [7:0] CMD_SEEK = 8'h0f;
  localparam logic [7:0] CMD_RW_END = 8'h06;
  localparam logic [7:0] CMD_SET_STANDBY = 8'h35;
  localparam logic [7:0] CMD_CLR_STANDBY = 8'h34;
  localparam logic [7:0] CMD_SOFT_RESET = 8'h36;
  // Result values and bit positions
  localparam logic [7:0] RES_INVALID = 8'h80;
  localparam logic [7:0] RES_SEEK_OK = 8'h20;
  localparam logic [7:0] RES_SEEK_BAD = 8'h60;
  localparam logic [7:0] RES_READY_CHG = 8'hc0;
  localparam int MAIN_DIR_BIT = 6;
  localparam int MAIN_RQM_BIT = 7;
  // Timing: clock rate and printed times
  localparam int CLK_HZ = 20000000;
  localparam int REF_HZ = 8000000;
  localparam int UNIT_US = 1000;
  localparam int UNIT_CYC = CLK_HZ / 1000000 * UNIT_US;
  localparam int STEP_HI_US = 7;
  localparam int STEP_HI_CYC = CLK_HZ / 1000000 * STEP_HI_US;
  localparam int FAULT_HI_US = 9;
  localparam int FAULT_HI_CYC = CLK_HZ / 1000000 * FAULT_HI_US;
  localparam int IDX_IGN_US = 200;
  localparam int IDX_IGN_CYC = CLK_HZ / 1000000 * IDX_IGN_US;
  localparam int WCK_HI_CYC = 2;
  localparam int WCK_PERIOD_CYC = 8;
  localparam logic [7:0] RECAL_MAX = 8'hff;
  localparam int UNLOAD_MS = 16;
  localparam int SETTLE_MS = 2;
  // Reset values
  localparam logic [3:0] RST_STEP = 4'hf;
  localparam logic [3:0] RST_UNLOAD = 4'hf;
  localparam logic [6:0] RST_SETTLE = 7'h01;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ARG = 5'b00010,
    ST_RESULT = 5'b00100,
    ST_STEP = 5'b01000,
    ST_FAULT = 5'b10000
  } fcc_state_t;

  // Drive-side pins carried together
  typedef struct packed {
    logic step;
    logic dir;
    logic head_load;
    logic fault_reset;
    logic write_timing_clock;
  } fcc_drive_t;

  typedef struct packed {
    fcc_state_t st;
    logic [1:0] arg_left;
    logic [7:0] opcode;
    logic [3:0] step_interval;
    logic [3:0] head_unload_interval;
    logic [6:0] head_settle_interval;
    logic transfer_mode_bit;
    logic seek_done_flag;
    logic seek_bad;
    logic ready_chg;
    logic pending_sense;
    logic irq;
    logic standby;
    logic [7:0] result;
    logic [7:0] pcn;
    logic [7:0] ncn;
    logic [7:0] recal_cnt;
    logic recal;
    logic [15:0] cyc;
    logic [15:0] unit_cnt;
    logic [7:0] units;
    logic unloading;
    logic settling;
    logic [15:0] idx_ign;
    logic idx_seen;
    logic [2:0] wck_cnt;
    logic ack;
    logic [31:0] rdata;
    logic ready_q;
    fcc_drive_t drv;
  } fcc_reg_t;
endpackage

// ==== hw/fcc_ctrl.sv ====
// Floppy control-command handler with classic Wishbone register slave
//
// The Wishbone interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module fcc_ctrl
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Drive inputs
  input wire logic track0,
  input wire logic index_in,
  input wire logic drive_ready,
  input wire logic drive_fault,
  input wire logic write_protect,
  input wire logic tunnel_erase,
  // Drive outputs
  output logic step,
  output logic dir,
  output logic head_load,
  output logic fault_reset,
  output logic write_timing_clock,
  // Host event outputs
  output logic irq,
  output logic index_pulse,
  output logic multitrack_ok,
  output logic standby
);
  fcc_pkg::fcc_reg_t s_q;
  fcc_pkg::fcc_reg_t s_d;
  logic wr;
  logic rd;
  logic [7:0] byte_in;
  logic [15:0] step_cyc;
  logic idx_q;
  logic mt_q;
  logic soft_rst;

  // Bus strobes; the low byte lane carries every register
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~s_q.ack & wb_sel_i[0];
  assign rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~s_q.ack;
  assign byte_in = wb_dat_i[7:0];
  // software reset code, taken unless it arrives as an argument byte
  assign soft_rst = wr && wb_adr_i == fcc_pkg::ADDR_CMD && byte_in == fcc_pkg::CMD_SOFT_RESET
    && s_q.st != fcc_pkg::ST_ARG;
  // inverse code, 0.1 ms units scaled to this clock
  assign step_cyc = 16'((5'h10 - {1'b0, s_q.step_interval}) * 16'(fcc_pkg::UNIT_CYC / 10));

  always_comb
  begin
    s_d = s_q;
    s_d.ack = wb_cyc_i & wb_stb_i & ~s_q.ack;
    s_d.ready_q = drive_ready;
    // Bus read mux; unmapped addresses read zero
    if (rd)
    begin
      unique case (wb_adr_i)
        fcc_pkg::ADDR_MAIN:
          s_d.rdata = {24'h0, (s_q.st != fcc_pkg::ST_STEP),
            (s_q.st == fcc_pkg::ST_RESULT), s_q.transfer_mode_bit, s_q.standby, 4'h0};
        fcc_pkg::ADDR_RESULT: s_d.rdata = {24'h0, s_q.result};
        fcc_pkg::ADDR_DRIVE:
          s_d.rdata = {24'h0, drive_fault, write_protect, drive_ready, track0, 4'h0};
        default: s_d.rdata = 32'h0;
      endcase
    end
    // Reading the result ends the result phase
    if (rd && wb_adr_i == fcc_pkg::ADDR_RESULT && s_q.st == fcc_pkg::ST_RESULT)
      s_d.st = fcc_pkg::ST_IDLE;
    // ready-line change is a sense cause
    if (drive_ready != s_q.ready_q)
    begin
      s_d.ready_chg = 1'b1;
      s_d.irq = 1'b1;
    end
    // Command byte decode
    if (wr && wb_adr_i == fcc_pkg::ADDR_CMD)
    begin
      if (s_q.st == fcc_pkg::ST_ARG)
      begin
        s_d.arg_left = s_q.arg_left - 2'd1;
        if (s_q.opcode == fcc_pkg::CMD_SPECIFY && s_q.arg_left == 2'd2)
        begin
          // first byte holds step and unload codes
          s_d.step_interval = byte_in[7:4];
          s_d.head_unload_interval = byte_in[3:0];
        end
        else if (s_q.opcode == fcc_pkg::CMD_SPECIFY)
        begin
          s_d.head_settle_interval = byte_in[7:1];
          s_d.transfer_mode_bit = byte_in[0];
        end
        else if (s_q.opcode == fcc_pkg::CMD_SEEK && s_q.arg_left == 2'd1)
          s_d.ncn = byte_in;
        if (s_q.arg_left == 2'd1)
        begin
          s_d.st = fcc_pkg::ST_IDLE;
          if (s_q.opcode == fcc_pkg::CMD_SEEK || s_q.opcode == fcc_pkg::CMD_RECAL)
          begin
            s_d.st = fcc_pkg::ST_STEP;
            s_d.cyc = 16'h0;
            s_d.drv.dir = (s_q.opcode == fcc_pkg::CMD_SEEK) && (s_d.ncn > s_q.pcn);
            s_d.drv.head_load = 1'b1;
          end
          if (s_q.opcode == fcc_pkg::CMD_DRIVE_STATUS)
          begin
            s_d.result = {drive_fault, write_protect, drive_ready, track0, 4'h0};
            s_d.st = fcc_pkg::ST_RESULT;
          end
        end
      end
      else if (s_q.st == fcc_pkg::ST_IDLE)
      begin
        s_d.opcode = byte_in;
        // unsensed seek interrupt invalidates next command
        if (s_q.pending_sense && byte_in != fcc_pkg::CMD_SENSE
            && byte_in != fcc_pkg::CMD_SOFT_RESET)
        begin
          s_d.result = fcc_pkg::RES_INVALID;
          s_d.st = fcc_pkg::ST_RESULT;
          s_d.pending_sense = 1'b0;
        end
        else
        begin
          unique case (byte_in)
            fcc_pkg::CMD_SPECIFY:
            begin
              s_d.st = fcc_pkg::ST_ARG;
              s_d.arg_left = 2'd2;
            end
            fcc_pkg::CMD_SEEK:
            begin
              s_d.st = fcc_pkg::ST_ARG;
              s_d.arg_left = 2'd2;
              s_d.recal = 1'b0;
            end
            fcc_pkg::CMD_RECAL:
            begin
              // up to 255 steps toward track zero
              s_d.st = fcc_pkg::ST_ARG;
              s_d.arg_left = 2'd1;
              s_d.recal = 1'b1;
              s_d.recal_cnt = fcc_pkg::RECAL_MAX;
              s_d.pcn = 8'h0;
            end
            fcc_pkg::CMD_DRIVE_STATUS:
            begin
              s_d.st = fcc_pkg::ST_ARG;
              s_d.arg_left = 2'd1;
            end
            fcc_pkg::CMD_SENSE:
            begin
              s_d.result = s_q.seek_done_flag ? (s_q.seek_bad ? fcc_pkg::RES_SEEK_BAD
                : fcc_pkg::RES_SEEK_OK) : (s_q.ready_chg ? fcc_pkg::RES_READY_CHG
                : fcc_pkg::RES_INVALID);
              s_d.seek_done_flag = 1'b0;
              s_d.ready_chg = 1'b0;
              s_d.pending_sense = 1'b0;
              s_d.irq = 1'b0;
              s_d.st = fcc_pkg::ST_RESULT;
            end
            fcc_pkg::CMD_RW_END:
            begin
              // unload interval starts at read/write end
              s_d.unloading = 1'b1;
              s_d.units = {4'h0, s_q.head_unload_interval};
              s_d.unit_cnt = 16'h0;
            end
            fcc_pkg::CMD_SET_STANDBY: s_d.standby = 1'b1;
            fcc_pkg::CMD_CLR_STANDBY: s_d.standby = 1'b0;
            fcc_pkg::CMD_SOFT_RESET: s_d.standby = s_q.standby;
            default:
            begin
              s_d.result = fcc_pkg::RES_INVALID;
              s_d.st = fcc_pkg::ST_RESULT;
            end
          endcase
        end
      end
    end
    // Stepping engine
    if (s_q.st == fcc_pkg::ST_STEP)
    begin
      s_d.cyc = s_q.cyc + 16'd1;
      // step high for the nominal width
      s_d.drv.step = (s_q.cyc < 16'(fcc_pkg::STEP_HI_CYC));
      if (s_q.cyc == 16'(fcc_pkg::STEP_HI_CYC))
      begin
        if (!s_q.recal)
          s_d.pcn = s_q.drv.dir ? s_q.pcn + 8'd1 : s_q.pcn - 8'd1;
        else
          s_d.recal_cnt = s_q.recal_cnt - 8'd1;
      end
      // End only between pulses, so a step pulse is never cut short
      if (s_q.cyc == 16'h0
          && ((s_q.recal && (track0 || s_q.recal_cnt == 8'h0)) || (!s_q.recal && s_q.pcn == s_q.ncn)))
      begin
        // seek end sets flag and interrupt
        s_d.st = fcc_pkg::ST_IDLE;
        s_d.drv.step = 1'b0;
        s_d.seek_done_flag = 1'b1;
        s_d.seek_bad = s_q.recal && !track0;
        s_d.pending_sense = 1'b1;
        s_d.irq = 1'b1;
        s_d.drv.fault_reset = drive_fault;
        s_d.cyc = 16'h0;
        if (drive_fault)
          s_d.st = fcc_pkg::ST_FAULT;
      end
      else if (s_q.cyc + 16'd1 >= step_cyc)
        s_d.cyc = 16'h0;
    end
    // fault reset pulse held within 8 to 10 us
    if (s_q.st == fcc_pkg::ST_FAULT)
    begin
      s_d.cyc = s_q.cyc + 16'd1;
      if (s_q.cyc == 16'(fcc_pkg::FAULT_HI_CYC - 1))
      begin
        s_d.drv.fault_reset = 1'b0;
        s_d.st = fcc_pkg::ST_IDLE;
      end
    end
    // unload timer in scaled ms units
    if (s_q.unloading)
    begin
      s_d.unit_cnt = s_q.unit_cnt + 16'd1;
      if (s_q.unit_cnt == 16'(fcc_pkg::UNIT_CYC * fcc_pkg::UNLOAD_MS / 20 - 1))
      begin
        s_d.unit_cnt = 16'h0;
        s_d.units = s_q.units - 8'd1;
        if (s_q.units <= 8'd1)
        begin
          s_d.unloading = 1'b0;
          s_d.drv.head_load = 1'b0;
        end
      end
    end
    // settling flag held clear at step start; no settle interval is timed
    if (s_q.drv.head_load && !s_q.settling && s_q.st == fcc_pkg::ST_STEP && s_q.cyc == 16'h0)
      s_d.settling = 1'b0;
    // index ignore window after a pulse
    s_d.idx_seen = 1'b0;
    if (s_q.idx_ign != 16'h0)
      s_d.idx_ign = s_q.idx_ign - 16'd1;
    else if (index_in)
    begin
      s_d.idx_seen = 1'b1;
      s_d.idx_ign = 16'(fcc_pkg::IDX_IGN_CYC);
    end
    // write timing clock high two cycles
    s_d.wck_cnt = s_q.wck_cnt + 3'd1;
    // High on the last counts of the period, so the first pulse after reset is full width
    s_d.drv.write_timing_clock =
      (s_d.wck_cnt >= 3'(fcc_pkg::WCK_PERIOD_CYC - fcc_pkg::WCK_HI_CYC));
  end

  // software reset acts like the reset input
  always_ff @(posedge core_clk)
  begin
    if (!rst_b || soft_rst)
    begin
      s_q <= '0;
      s_q.st <= fcc_pkg::ST_IDLE;
      s_q.step_interval <= fcc_pkg::RST_STEP;
      s_q.head_unload_interval <= fcc_pkg::RST_UNLOAD;
      s_q.head_settle_interval <= fcc_pkg::RST_SETTLE;
      s_q.ack <= wb_cyc_i & wb_stb_i & rst_b;
    end
    else
      s_q <= s_d;
  end

  // multitrack write needs tunnel erase head
  always_ff @(posedge core_clk)
  begin
    if (!rst_b || soft_rst)
    begin
      idx_q <= 1'b0;
      mt_q <= 1'b0;
    end
    else
    begin
      idx_q <= s_q.idx_seen;
      mt_q <= tunnel_erase;
    end
  end

  // Outputs straight from flip-flops
  assign wb_dat_o = s_q.rdata;
  assign wb_ack_o = s_q.ack;
  assign step = s_q.drv.step;
  assign dir = s_q.drv.dir;
  assign head_load = s_q.drv.head_load;
  assign fault_reset = s_q.drv.fault_reset;
  assign write_timing_clock = s_q.drv.write_timing_clock;
  assign irq = s_q.irq;
  assign index_pulse = idx_q;
  assign multitrack_ok = mt_q;
  assign standby = s_q.standby;
endmodule
`default_nettype wire

// ==== verif/fcc_ctrl_checker.sv ====
// Port-level assertion checker for the control-command handler
`timescale 1ns/1ps
`default_nettype none
module fcc_ctrl_checker
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  // Drive and host pins
  input wire logic tunnel_erase,
  input wire logic step,
  input wire logic fault_reset,
  input wire logic write_timing_clock,
  input wire logic irq,
  input wire logic index_pulse,
  input wire logic multitrack_ok,
  input wire logic standby
);
  localparam int IGN_CYC = 4000;
  logic wr_cmd;
  logic [3:0] soft_q;
  logic [15:0] hi_q;
  logic [15:0] gap_q;
  // Command byte write decode
  assign wr_cmd = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && wb_adr_i == fcc_pkg::ADDR_CMD;
  // Soft reset window masks checks, since it cuts pulses short on purpose
  always_ff @(posedge core_clk)
  begin
    soft_q <= {soft_q[2:0], wr_cmd && wb_dat_i[7:0] == fcc_pkg::CMD_SOFT_RESET};
    hi_q <= (step || fault_reset) ? hi_q + 16'h0001 : 16'h0000;
    if (!rst_b)
      gap_q <= 16'hffff;
    else if (index_pulse)
      gap_q <= 16'h0001;
    else if (gap_q != 16'hffff)
      gap_q <= gap_q + 16'h0001;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b || soft_q != 4'h0);
  chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack did not follow request");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_step_width: assert property ($fell(step) |-> hi_q >= 16'h0078 && hi_q <= 16'h00a0)
    else $error("step pulse width wrong");
  chk_fault_width: assert property ($fell(fault_reset) |-> hi_q >= 16'h00a0 && hi_q <= 16'h00c8)
    else $error("fault reset width wrong");
  chk_wck_high: assert property ($rose(write_timing_clock) |=> write_timing_clock ##1 !write_timing_clock)
    else $error("write clock high time wrong");
  chk_index_gap: assert property (index_pulse |-> (gap_q >= IGN_CYC - 1) ##1 !index_pulse)
    else $error("index accepted inside ignore span");
  chk_irq_hold: assert property ($fell(irq) |-> $past(wr_cmd && wb_dat_i[7:0] == fcc_pkg::CMD_SENSE))
    else $error("irq dropped without sense");
  chk_standby_on: assert property (wr_cmd && wb_ack_o && wb_dat_i[7:0] == 8'h35 |=> standby)
    else $error("standby not entered");
  chk_standby_off: assert property (wr_cmd && wb_ack_o && wb_dat_i[7:0] == 8'h34 |=> !standby)
    else $error("standby not left");
  chk_mt_follow: assert property (##1 multitrack_ok == $past(tunnel_erase))
    else $error("multitrack flag stale");
  cover property ($rose(irq));
  cover property ($fell(step));
  cover property ($rose(standby));
endmodule
bind fcc_ctrl fcc_ctrl_checker u_chk (.core_clk(core_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .tunnel_erase(tunnel_erase), .step(step),
  .fault_reset(fault_reset), .write_timing_clock(write_timing_clock), .irq(irq),
  .index_pulse(index_pulse), .multitrack_ok(multitrack_ok), .standby(standby));
`default_nettype wire

// ==== verif/fcc_drive_model.sv ====
// Behavioural floppy drive: head position, index, ready and erase lines
`timescale 1ns/1ps
`default_nettype none
module fcc_drive_model
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // From the controller
  input wire logic step,
  input wire logic dir,
  // To the controller
  output logic track0,
  output logic index_in,
  output logic drive_ready,
  output logic drive_fault,
  output logic write_protect,
  output logic tunnel_erase
);
  logic [7:0] cyl = 8'h01;
  logic [15:0] t = 16'h0000;
  logic step_q = 1'b0;
  // Head moves on each step edge; time saturates so the index pattern runs once
  always_ff @(posedge core_clk)
  begin
    step_q <= step;
    if (!rst_b)
      t <= 16'h0000;
    else if (t != 16'hffff)
      t <= t + 16'h0001;
    if (step && !step_q && dir)
      cyl <= cyl + 8'h01;
    else if (step && !step_q && cyl != 8'h00)
      cyl <= cyl - 8'h01;
  end
  // Second index falls inside the ignore span, third outside it
  assign index_in = (t - 16'h03e8 < 16'h000a) || (t - 16'h09c4 < 16'h000a) || (t - 16'h1770 < 16'h000a);
  // Ready rises shortly after reset, giving one ready-change event
  assign drive_ready = t > 16'h0032;
  assign track0 = cyl == 8'h00;
  // Cylinder two is faulty, so a seek there ends with a fault reset pulse
  assign drive_fault = cyl == 8'h02;
  assign write_protect = 1'b0;
  assign tunnel_erase = t[12];
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
// Self-checking bench for the control-command handler
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, q;
  logic ack, track0, index_in, drive_ready, drive_fault, write_protect, tunnel_erase;
  logic step, dir, head_load, fault_reset, wtc, irq, index_pulse, mt_ok, standby;
  int error_cnt = 0;
  int n_checks = 0;
  int idx_cnt = 0;
  int flt_cnt = 0;
  logic flt_q = 1'b0;
  always #25 core_clk = ~core_clk;
  // Accepted index pulses and fault reset pulses
  always @(posedge core_clk)
  begin
    flt_q <= fault_reset;
    if (index_pulse === 1'b1)
      idx_cnt++;
    if (fault_reset === 1'b1 && flt_q === 1'b0)
      flt_cnt++;
  end
  fcc_ctrl u_dut (.core_clk(core_clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .track0(track0), .index_in(index_in), .drive_ready(drive_ready),
    .drive_fault(drive_fault), .write_protect(write_protect), .tunnel_erase(tunnel_erase),
    .step(step), .dir(dir), .head_load(head_load), .fault_reset(fault_reset),
    .write_timing_clock(wtc), .irq(irq), .index_pulse(index_pulse),
    .multitrack_ok(mt_ok), .standby(standby));
  fcc_drive_model u_drv (.core_clk(core_clk), .rst_b(rst_b), .step(step), .dir(dir),
    .track0(track0), .index_in(index_in), .drive_ready(drive_ready),
    .drive_fault(drive_fault), .write_protect(write_protect), .tunnel_erase(tunnel_erase));
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One classic cycle, held until the edge that samples ack
  task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    wdat <= {24'h0, d};
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1)
      error_cnt++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] d);
    xfer(1'b1, fcc_pkg::ADDR_CMD, d);
  endtask
  task automatic rd(input logic [3:0] a);
    xfer(1'b0, a, 8'h00);
  endtask
  // Bounded wait on the interrupt line
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 5000)
    begin
      @(posedge core_clk);
      n++;
    end
    if (irq !== 1'b1)
      error_cnt++;
  endtask
  task automatic sense_chk(input logic [7:0] exp);
    wr(fcc_pkg::CMD_SENSE);
    rd(fcc_pkg::ADDR_RESULT);
    check("sense result", q, {24'h0, exp});
    check("irq cleared", 32'(irq), 32'h0);
  endtask
  // Main sequence
  initial
  begin
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(4'h2);
    check("unmapped", q, 32'h0);
    wait_irq();
    sense_chk(8'hc0);
    wr(8'hff);
    rd(fcc_pkg::ADDR_MAIN);
    check("main flags", 32'(q[7:6]), 32'h3);
    check("no irq", 32'(irq), 32'h0);
    rd(fcc_pkg::ADDR_RESULT);
    check("invalid result", q, 32'h80);
    wr(8'h35);
    check("standby", 32'(standby), 32'h1);
    wr(8'h34);
    check("standby", 32'(standby), 32'h0);
    for (int m = 1; m >= 0; m--)
    begin
      wr(fcc_pkg::CMD_SPECIFY);
      wr(8'hf0);
      wr(8'h02 | 8'(m));
      rd(fcc_pkg::ADDR_MAIN);
      check("transfer mode", 32'(q[5]), 32'(m));
    end
    wr(fcc_pkg::CMD_SPECIFY);
    wr(8'hf0);
    wr(8'h03);
    wr(8'h35);
    wr(8'h36);
    rd(fcc_pkg::ADDR_MAIN);
    check("soft reset", 32'({q[5], standby}), 32'h0);
    wait_irq();
    sense_chk(8'hc0);
    wr(fcc_pkg::CMD_RECAL);
    wr(8'h00);
    wait_irq();
    check("recal irq", 32'(irq), 32'h1);
    check("cylinder", 32'(u_drv.cyl), 32'h0);
    wr(fcc_pkg::CMD_DRIVE_STATUS);
    wr(8'h00);
    rd(fcc_pkg::ADDR_RESULT);
    check("unsensed", q, 32'h80);
    sense_chk(8'h20);
    wr(fcc_pkg::CMD_DRIVE_STATUS);
    wr(8'h00);
    rd(fcc_pkg::ADDR_RESULT);
    check("status query", q, 32'h30);
    wr(fcc_pkg::CMD_SEEK);
    wr(8'h00);
    wr(8'h01);
    wait_irq();
    sense_chk(8'h20);
    check("cylinder", 32'(u_drv.cyl), 32'h1);
    check("head load", 32'(head_load), 32'h1);
    // Seek to the faulty cylinder: step in, then a fault reset pulse
    wr(fcc_pkg::CMD_SEEK);
    wr(8'h00);
    wr(8'h02);
    wait_irq();
    check("direction", 32'(dir), 32'h1);
    repeat (200) @(posedge core_clk);
    sense_chk(8'h20);
    check("fault pulses", flt_cnt, 32'h1);
    // Unload code one, then a read/write end starts the unload interval
    wr(fcc_pkg::CMD_SPECIFY);
    wr(8'hf1);
    wr(8'h03);
    wr(fcc_pkg::CMD_RW_END);
    repeat (15990) @(posedge core_clk);
    check("head held", 32'(head_load), 32'h1);
    repeat (20) @(posedge core_clk);
    check("head unloaded", 32'(head_load), 32'h0);
    check("index count", idx_cnt, 32'h2);
    summarize();
  end
  // Watchdog: the tests need roughly 22500 cycles, well inside this span
  initial
  begin
    repeat (40000) @(posedge core_clk);
    error_cnt++;
    summarize();
  end
endmodule
`default_nettype wire
